// ### rtl/orpl_pkg.sv
// Package for the OR and pointer-load execute block.
// Assumes a 16-bit instruction word and an 8-bit data path.
package orpl_pkg;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned PTR_W        = 12;
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned NUM_PTR      = 3;
  localparam logic [7:0]  OP_ORLIT     = 8'h09;
  localparam logic [5:0]  OP_ORREG     = 6'h04;
  localparam logic [9:0]  OP_LDPTR     = 10'h3B8;
  localparam logic [7:0]  OP_LDPTR_2ND = 8'hF0;
  localparam int unsigned D_BIT        = 9;
  localparam int unsigned A_BIT        = 8;
  localparam int unsigned UPPER_LSB    = 8;
  localparam int unsigned OPC_REG_LSB  = 10;
  localparam int unsigned OPC_PTR_LSB  = 6;
  localparam int unsigned PSEL_LSB     = 4;
  localparam int unsigned PSEL_W       = 2;
  localparam logic [3:0]  ACCESS_BANK  = 4'h0;
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;

  typedef enum logic [3:0] {
    ORPL_Q1 = 4'h1,
    ORPL_Q2 = 4'h2,
    ORPL_Q3 = 4'h4,
    ORPL_Q4 = 4'h8
  } orpl_phase_type;
endpackage

// ### rtl/orpl_phase_if.sv
// Phase carrier between the sequencer and the execute core.
// Assumes one clock; phases advance every rising clk_sys edge.
`timescale 1ns/10ps
`default_nettype none
interface orpl_phase_if;
  orpl_pkg::orpl_phase_type phase;
  logic                     cycle_end;
  modport seq  (output phase, output cycle_end);
  modport core (input phase, input cycle_end);
endinterface
`default_nettype wire

// ### rtl/orpl_phase_seq.sv
// Four-phase instruction cycle sequencer.
// Assumes synchronous active-high reset on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module orpl_phase_seq (
  input  wire logic   clk_sys,
  input  wire logic   reset,
  orpl_phase_if.seq   ph
);
  orpl_pkg::orpl_phase_type phase_ff;
  orpl_pkg::orpl_phase_type nxt_phase;

  always_comb begin
    case (phase_ff)
      orpl_pkg::ORPL_Q1: nxt_phase = orpl_pkg::ORPL_Q2;
      orpl_pkg::ORPL_Q2: nxt_phase = orpl_pkg::ORPL_Q3;
      orpl_pkg::ORPL_Q3: nxt_phase = orpl_pkg::ORPL_Q4;
      default:           nxt_phase = orpl_pkg::ORPL_Q1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase_ff <= orpl_pkg::ORPL_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign ph.phase     = phase_ff;
  assign ph.cycle_end = (phase_ff == orpl_pkg::ORPL_Q4);
endmodule
`default_nettype wire

// ### rtl/orpl_exec.sv
// Execute logic for literal-OR, register-OR and two-word pointer load.
// Assumes instr is stable for a whole instruction cycle and the data
// memory answers mem_rdata combinationally from mem_addr.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Literal-OR ORs the low-byte literal into the accumulator and sets N and Z.
// - Register-OR ORs the accumulator with the addressed register and sets N and Z.
// - Register-OR result goes to the accumulator when d is 0 and back to the register when d is 1.
// - Bank bit 0 selects the access bank ignoring the bank select value; 1 uses the bank select value.
// - Pointer load puts a 12-bit literal into pointer 0 to 2 over two words and two cycles, flags untouched.
// - First cycle writes the upper four literal bits to pointer bits 11:8, second writes the low byte.
module orpl_exec #(
  parameter int unsigned NUM_PTR = orpl_pkg::NUM_PTR
) (
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  input  wire logic [orpl_pkg::WORD_W-1:0]       instr,
  input  wire logic [3:0]                        bank_select_value,
  input  wire logic [orpl_pkg::DATA_W-1:0]       mem_rdata,
  output logic      [orpl_pkg::ADDR_W-1:0]       mem_addr,
  output logic      [orpl_pkg::DATA_W-1:0]       mem_wdata,
  output logic                                   mem_we,
  output logic      [orpl_pkg::DATA_W-1:0]       acc,
  output logic                                   flag_n,
  output logic                                   flag_z,
  output logic      [NUM_PTR*orpl_pkg::PTR_W-1:0] pointers,
  output logic                                   second_word,
  output logic                                   cycle_end
);
  localparam int unsigned DW = orpl_pkg::DATA_W;
  localparam int unsigned PW = orpl_pkg::PTR_W;
  localparam int unsigned HW = PW - DW;

  typedef logic [orpl_pkg::WORD_W-1:0] orpl_word_type;
  localparam orpl_word_type CODE_LIT  = orpl_word_type'(orpl_pkg::OP_ORLIT);
  localparam orpl_word_type CODE_REG  = orpl_word_type'(orpl_pkg::OP_ORREG);
  localparam orpl_word_type CODE_PTR  = orpl_word_type'(orpl_pkg::OP_LDPTR);
  localparam orpl_word_type CODE_PTR2 = orpl_word_type'(orpl_pkg::OP_LDPTR_2ND);

  // Opcode fields sit at different heights; one compare serves every decode
  function automatic logic opcode_is(
    input orpl_word_type word,
    input int unsigned   lsb,
    input orpl_word_type code
  );
    return (word >> lsb) == code;
  endfunction

  function automatic logic [orpl_pkg::PSEL_W-1:0] ptr_field(input orpl_word_type word);
    return word[orpl_pkg::PSEL_LSB +: orpl_pkg::PSEL_W];
  endfunction

  orpl_phase_if ph ();

  orpl_phase_seq u_seq (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ph      (ph)
  );

  logic [DW-1:0] acc_ff;
  logic          flag_n_ff;
  logic          flag_z_ff;
  logic [PW-1:0] ptr_ff [NUM_PTR];
  logic          second_ff;
  logic [1:0]    ptr_sel_ff;
  logic [DW-1:0] operand_ff;
  logic [DW-1:0] result_ff;
  logic          is_orlit_ff;
  logic          is_orreg_ff;
  logic          is_ldptr_ff;
  logic          wr_reg;
  logic          acc_we;
  logic          flag_we;
  logic          ptr_hi_we;
  logic          ptr_lo_we;
  logic [DW-1:0] nxt_acc;

  // Decode in Q1; latched so the rest of the cycle needs no re-decode.
  // A pointer load's second word is data and must never decode as an opcode.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      is_orlit_ff <= 1'b0;
    end else if (ph.phase == orpl_pkg::ORPL_Q1) begin
      is_orlit_ff <= !second_ff && opcode_is(instr, orpl_pkg::UPPER_LSB, CODE_LIT);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      is_orreg_ff <= 1'b0;
    end else if (ph.phase == orpl_pkg::ORPL_Q1) begin
      is_orreg_ff <= !second_ff && opcode_is(instr, orpl_pkg::OPC_REG_LSB, CODE_REG);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      is_ldptr_ff <= 1'b0;
    end else if (ph.phase == orpl_pkg::ORPL_Q1) begin
      is_ldptr_ff <= !second_ff && opcode_is(instr, orpl_pkg::OPC_PTR_LSB, CODE_PTR)
                     && int'(ptr_field(instr)) < NUM_PTR;
    end
  end

  // Register address: access bank or banked.
  // Straight from instr so the data memory can answer inside Q2.
  always_comb begin
    if (!instr[orpl_pkg::A_BIT]) begin
      mem_addr = {orpl_pkg::ACCESS_BANK, instr[7:0]};
    end else begin
      mem_addr = {bank_select_value, instr[7:0]};
    end
  end

  // Q2 operand read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      operand_ff <= '0;
    end else if (ph.phase == orpl_pkg::ORPL_Q2) begin
      operand_ff <= is_orreg_ff ? mem_rdata : instr[7:0];
    end
  end

  // Q3 process
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      result_ff <= '0;
    end else if (ph.phase == orpl_pkg::ORPL_Q3) begin
      result_ff <= acc_ff | operand_ff;
    end
  end

  assign wr_reg    = is_orreg_ff && instr[orpl_pkg::D_BIT];
  assign acc_we    = (ph.phase == orpl_pkg::ORPL_Q4) && (is_orlit_ff || (is_orreg_ff && !wr_reg));
  assign flag_we   = (ph.phase == orpl_pkg::ORPL_Q4) && (is_orlit_ff || is_orreg_ff);
  assign ptr_hi_we = (ph.phase == orpl_pkg::ORPL_Q4) && is_ldptr_ff;
  assign ptr_lo_we = (ph.phase == orpl_pkg::ORPL_Q4) && second_ff
                     && opcode_is(instr, orpl_pkg::UPPER_LSB, CODE_PTR2);

  // Next accumulator: the OR result in Q4, otherwise held
  always_comb begin
    nxt_acc = acc_ff;
    if (acc_we) begin
      nxt_acc = result_ff;
    end
  end

  // Q4 write: accumulator unless register-OR with d set
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_ff <= orpl_pkg::ACC_RESET;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // Flags follow the OR result even when it goes back to the register;
  // a pointer load never touches them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_n_ff <= 1'b0;
    end else if (flag_we) begin
      flag_n_ff <= result_ff[DW-1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_z_ff <= 1'b0;
    end else if (flag_we) begin
      flag_z_ff <= (result_ff == '0);
    end
  end

  // Write strobe held for Q4 only
  assign mem_we    = (ph.phase == orpl_pkg::ORPL_Q4) && wr_reg;
  assign mem_wdata = result_ff;

  // Two-word sequence: second word consumed in the following cycle.
  // A refused pointer number never raises it, so its next word runs as an instruction.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      second_ff <= 1'b0;
    end else if (ph.phase == orpl_pkg::ORPL_Q4) begin
      second_ff <= is_ldptr_ff;
    end
  end

  // The second word has no pointer field, so the first word's choice is kept
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ptr_sel_ff <= '0;
    end else if (ptr_hi_we) begin
      ptr_sel_ff <= ptr_field(instr);
    end
  end

  // Pointer bytes written in Q4 of each of the two cycles
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        ptr_ff[i] <= orpl_pkg::PTR_RESET;
      end
    end else if (ptr_hi_we) begin
      ptr_ff[ptr_field(instr)][PW-1:DW] <= instr[HW-1:0];
    end else if (ptr_lo_we) begin
      ptr_ff[ptr_sel_ff][DW-1:0] <= instr[DW-1:0];
    end
  end

  // Flat bus keeps the top-level ports plain
  always_comb begin
    for (int i = 0; i < NUM_PTR; i++) begin
      pointers[i*PW +: PW] = ptr_ff[i];
    end
  end

  assign acc         = acc_ff;
  assign flag_n      = flag_n_ff;
  assign flag_z      = flag_z_ff;
  assign second_word = second_ff;
  assign cycle_end   = ph.cycle_end;
endmodule
`default_nettype wire

// ### tb/orpl_chk.sv
// Assertions for the OR and pointer-load execute block.
// Sees only top-level ports; bound from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module orpl_chk (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [15:0] instr,
  input wire logic [3:0]  bank_select_value,
  input wire logic [7:0]  mem_rdata,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_we,
  input wire logic [7:0]  acc,
  input wire logic        flag_n,
  input wire logic        flag_z,
  input wire logic        second_word,
  input wire logic        cycle_end
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic orlit = cycle_end && !second_word && instr[15:8] == 8'h09;
  wire logic orreg = cycle_end && !second_word && instr[15:10] == 6'h04;
  wire logic ldptr = cycle_end && !second_word && instr[15:6] == 10'h3B8;
  property p_we; mem_we |-> orreg && instr[9]; endproperty
  a_we: assert property (p_we) else $error("write strobe without d=1 register-OR");
  property p_addr; orreg |-> mem_addr == {instr[8] ? bank_select_value : 4'h0, instr[7:0]}; endproperty
  a_addr: assert property (p_addr) else $error("bad register address");
  property p_orlit; orlit |=> acc == ($past(acc) | $past(instr[7:0])); endproperty
  a_orlit: assert property (p_orlit) else $error("literal OR result wrong");
  property p_orreg; orreg && !instr[9] |=> acc == ($past(acc) | $past(mem_rdata)); endproperty
  a_orreg: assert property (p_orreg) else $error("register OR result wrong");
  property p_wdata; mem_we |-> mem_wdata == (acc | mem_rdata) ##1 $stable(acc); endproperty
  a_wdata: assert property (p_wdata) else $error("write-back data or accumulator wrong");
  property p_flags; orlit || orreg && !instr[9] |=> flag_n == acc[7] && flag_z == (acc == 8'h00); endproperty
  a_flags: assert property (p_flags) else $error("flags do not match result");
  property p_ptrflags; ldptr |=> $stable({flag_n, flag_z}); endproperty
  a_ptrflags: assert property (p_ptrflags) else $error("pointer load touched flags");
  property p_cyc; $rose(cycle_end) |=> !cycle_end [*3] ##1 cycle_end; endproperty
  a_cyc: assert property (p_cyc) else $error("cycle is not four clocks");
  property p_second; ldptr && instr[5:4] != 2'h3 |=> second_word; endproperty
  a_second: assert property (p_second) else $error("second word not flagged");
  c_orlit: cover property (orlit);
  c_we: cover property (mem_we);
  c_second: cover property ($rose(second_word));
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the OR and pointer-load execute block.
// Drives every port itself; memory read data is a held input.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t mismatch", $time); end end
module tb;
  typedef struct {logic [15:0] ins; logic [7:0] rd; logic [3:0] bk; logic [7:0] acc; logic we; logic [11:0] adr;} orpl_row_type;
  orpl_row_type rows [5] = '{'{16'h0900, 8'h00, 4'h0, 8'h00, 1'b0, 12'h000}, '{16'h0991, 8'h00, 4'h0, 8'h91, 1'b0, 12'h000},
    '{16'h1133, 8'h13, 4'hA, 8'h93, 1'b0, 12'hA33}, '{16'h1255, 8'h24, 4'h7, 8'h93, 1'b1, 12'h055},
    '{16'h0935, 8'h00, 4'h0, 8'hB7, 1'b0, 12'h000}};
  logic        clk_sys, reset, mem_we, flag_n, flag_z, second_word, cycle_end, we_q, sw_q;
  logic [15:0] instr;
  logic [3:0]  bank_select_value;
  logic [7:0]  mem_rdata, mem_wdata, acc, wd_q, pacc;
  logic [11:0] mem_addr, adr_q;
  logic [35:0] pointers;
  int          mismatches = 0, compares = 0;
  orpl_exec u_dut (.clk_sys, .reset, .instr, .bank_select_value, .mem_rdata, .mem_addr, .mem_wdata, .mem_we,
    .acc, .flag_n, .flag_z, .pointers, .second_word, .cycle_end);
  task automatic run(input logic [15:0] i, input logic [7:0] r, input logic [3:0] b);
    instr = i;
    mem_rdata = r;
    bank_select_value = b;
    @(negedge clk_sys);
    while (cycle_end !== 1'b1) @(negedge clk_sys);
    {we_q, adr_q, wd_q, sw_q} = {mem_we, mem_addr, mem_wdata, second_word};
    @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  initial begin
    {reset, instr, mem_rdata, bank_select_value, pacc} = {1'b1, 16'h0000, 8'h00, 4'h0, 8'h00};
    repeat (5) @(posedge clk_sys);
    #1 reset = 1'b0;
    foreach (rows[k]) begin
      run(rows[k].ins, rows[k].rd, rows[k].bk);
      `CHK(acc, rows[k].acc)
      `CHK({flag_n, flag_z}, {rows[k].acc[7], rows[k].acc == 8'h00})
      if (rows[k].ins[15:10] == 6'h04) `CHK({we_q, adr_q}, {rows[k].we, rows[k].adr})
      if (rows[k].we) `CHK(wd_q, pacc | rows[k].rd)
      pacc = rows[k].acc;
      $display("row %0d done", k);
    end
    run(16'hEE23, 8'h00, 4'h0);
    `CHK(pointers[35:24], 12'h300)
    run(16'hF0AB, 8'h00, 4'h0);
    `CHK({sw_q, pointers[35:24], flag_n, flag_z}, {1'b1, 12'h3AB, 2'b10})
    run(16'hEE0F, 8'h00, 4'h0);
    run(16'hF0FF, 8'h00, 4'h0);
    run(16'hEE3F, 8'h00, 4'h0);
    run(16'hF0FF, 8'h00, 4'h0);
    run(16'hEE15, 8'h00, 4'h0);
    run(16'h1234, 8'h5A, 4'h0);
    `CHK({sw_q, we_q, acc}, {2'b10, 8'hB7})
    `CHK(pointers, {12'h3AB, 12'h500, 12'hFFF})
    $display("pointer load done");
    reset = 1'b1;
    @(posedge clk_sys);
    #1 reset = 1'b0;
    run(16'h0901, 8'h00, 4'h0);
    `CHK({acc, pointers, flag_n, flag_z}, {8'h01, 36'h0, 2'b00})
    run(16'h1280, 8'h80, 4'h0);
    `CHK({we_q, adr_q, wd_q, acc, flag_n, flag_z}, {1'b1, 12'h080, 8'h81, 8'h01, 2'b10})
    $display("reset done");
    complete_run();
  end
endmodule
bind orpl_exec orpl_chk u_chk (.clk_sys, .reset, .instr, .bank_select_value, .mem_rdata, .mem_addr, .mem_wdata,
  .mem_we, .acc, .flag_n, .flag_z, .second_word, .cycle_end);
`default_nettype wire
